// ===== hw/dcs_pkg.sv
// Shared constants, types and register map of the decade counter block.
package dcs_pkg;

  // System clock rate in MHz; every time below is converted with it.
  localparam int unsigned DCS_CLK_MHZ = 100;
  // Self-running interdigit blanking time after each scan rise, in ns.
  localparam int unsigned DCS_BLANK_NS = 5000;
  // Blanking cycles, rounded up to whole clocks.
  localparam int unsigned DCS_BLANK_CYC =
    (DCS_BLANK_NS * DCS_CLK_MHZ + 999) / 1000;
  // Least time a load input must lead a strobe rise, in ns.
  localparam int unsigned DCS_LOAD_SETUP_NS = 2000;
  // Load setup in cycles, rounded up as a least time.
  localparam int unsigned DCS_LOAD_SETUP_CYC =
    (DCS_LOAD_SETUP_NS * DCS_CLK_MHZ + 999) / 1000;

  // Number of decades and width of the blanking and setup timers.
  localparam int DCS_DIGITS = 6;
  localparam int DCS_TIMER_W = 12;
  localparam logic [3:0] DCS_BCD_MAX = 4'h9;
  localparam logic [3:0] DCS_BCD_ZERO = 4'h0;

  // Segment patterns for 0..9, bit order {g,f,e,d,c,b,a}, lit when high.
  localparam logic [9:0][6:0] DCS_SEG_TAB = {
    7'h6F, 7'h7F, 7'h07, 7'h7D, 7'h6D,
    7'h66, 7'h4F, 7'h5B, 7'h06, 7'h3F
  };

  // APB register byte offsets.
  localparam int DCS_AW = 12;
  localparam logic [DCS_AW-1:0] DCS_REG_CTRL = 12'h000;
  localparam logic [DCS_AW-1:0] DCS_REG_STATUS = 12'h004;
  localparam logic [DCS_AW-1:0] DCS_REG_COUNT = 12'h008;
  localparam logic [DCS_AW-1:0] DCS_REG_LATCH = 12'h00C;
  localparam logic [DCS_AW-1:0] DCS_REG_COMPARE = 12'h010;

  // Control register layout and reset value.
  localparam int DCS_CTRL_W = 2;
  localparam int DCS_CTRL_HOLD = 0;
  localparam int DCS_CTRL_STORE = 1;
  localparam logic [DCS_CTRL_W-1:0] DCS_CTRL_RST = 2'h0;

  // Status register field positions.
  localparam int DCS_ST_ZERO = 0;
  localparam int DCS_ST_EQUAL = 1;
  localparam int DCS_ST_CARRY = 2;
  localparam int DCS_ST_INH = 4;
  localparam int DCS_ST_BLANK = 6;
  localparam int DCS_ST_RING = 8;

  // Scan ring states, one hot; D6 is top_digit, D1 is bottom_digit.
  typedef enum logic [5:0] {
    RING_D6 = 6'h20,
    RING_D5 = 6'h10,
    RING_D4 = 6'h08,
    RING_D3 = 6'h04,
    RING_D2 = 6'h02,
    RING_D1 = 6'h01
  } dcs_ring_t;

  // Device input pins, all synchronous to pclk except clear, which acts asynchronously.
  typedef struct packed {
    logic count_in;
    logic dir_up;
    logic count_hold;
    logic clear;
    logic store;
    logic load_cnt;
    logic load_reg;
    logic scan_in;
    logic scan_home_n;
    logic zero_suppress_disable;
  } dcs_pins_t;

  // Counter flag outputs.
  typedef struct packed {
    logic zero;
    logic equal;
    logic carry;
  } dcs_flags_t;

  // Multiplexed display outputs.
  typedef struct packed {
    logic [5:0] strobe;
    logic [3:0] bcd;
    logic [6:0] seg;
  } dcs_disp_t;

endpackage : dcs_pkg

// ===== hw/dcs_decade.sv
// One BCD decade stepping up or down with its ripple carry.
`timescale 1ns/100ps
`default_nettype none
module dcs_decade (
  input wire logic [3:0] digit,
  input wire logic up,
  input wire logic en,
  output logic [3:0] next,
  output logic carry
);
  import dcs_pkg::*;

  // A decade passes the step on when it wraps in the counting direction.
  assign carry = en & (up ? (digit == DCS_BCD_MAX) : (digit == DCS_BCD_ZERO));

  // Next value of the decade; unchanged when not enabled.
  always_comb begin
    next = digit;
    if (en && up) begin
      next = (digit == DCS_BCD_MAX) ? DCS_BCD_ZERO : 4'(digit + 4'h1);
    end else if (en) begin
      next = (digit == DCS_BCD_ZERO) ? DCS_BCD_MAX : 4'(digit - 4'h1);
    end
  end

endmodule : dcs_decade
`default_nettype wire

// ===== hw/dcs_seg7.sv
// BCD to seven-segment decoder, segments lit high.
`timescale 1ns/100ps
`default_nettype none
module dcs_seg7 (
  input wire logic [3:0] bcd,
  output logic [6:0] seg
);
  import dcs_pkg::*;

  // Codes above nine light nothing rather than a stray pattern.
  assign seg = (bcd <= DCS_BCD_MAX) ? DCS_SEG_TAB[bcd] : 7'h00;

endmodule : dcs_seg7
`default_nettype wire

// ===== hw/dcs_top.sv
// Six-decade counter with compare register, flags and display scan.
//
// Overview of operation
// RULE1: Count rising edge steps counter, direction selects.
// RULE2: Hold input high freezes the counter.
// RULE3: Clear zeroes counter only, asynchronously.
// RULE4: Store low: latch follows; high: latch holds.
// RULE5: All flags, strobes, segments are active high.
// RULE6: Zero flag for one count period.
// RULE7: Zero flag forced off during counter load.
// RULE8: Equal flag when counter matches compare register.
// RULE9: Loads suppress equal until next blanking.
// RULE10: Carry at wrap, dropped on count falling edge.
// RULE11: Compare register loads per digit like counter.
// RULE12: Clear leaves compare register intact.
// RULE13: Compare register never reaches display outputs.
// RULE14: Six-state ring scans top to bottom digit.
// RULE15: Scan home low: ring at top, segments blank.
// RULE16: Home low shows top digit; release resumes.
// RULE17: Blanking blanks segments and digit strobes.
// RULE18: Leading-zero blanking on segments, disable input.
// RULE19: BCD output changes at blanking start.
// RULE20: Blanking is scan low time plus blank time.
// RULE21: Brightness follows external scan duty cycle.
// RULE22: Controller aligns load fall with scan rise.
// RULE23: Suppression ends only with 2 us margin.
// RULE24: Flags not meaningful above 1 MHz count.
// RULE25: All inputs sampled and edge-detected on pclk; code edge-detects only count, scan and loads; clear is asynchronous.
`timescale 1ns/100ps
`default_nettype none
module dcs_top #(
  parameter int unsigned BLANK_CYC = dcs_pkg::DCS_BLANK_CYC,
  parameter int unsigned LOAD_SETUP_CYC = dcs_pkg::DCS_LOAD_SETUP_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [dcs_pkg::DCS_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output var logic [31:0] prdata,
  output var logic pready,
  output var logic pslverr,
  input wire dcs_pkg::dcs_pins_t pins,
  input wire logic [3:0] cnt_bcd_in,
  input wire logic [3:0] reg_bcd_in,
  output var dcs_pkg::dcs_flags_t flags,
  output var dcs_pkg::dcs_disp_t disp
);
  import dcs_pkg::*;

  // Timer reload values at the timer's own width.
  localparam logic [DCS_TIMER_W-1:0] BLANK_LD = DCS_TIMER_W'(BLANK_CYC);
  localparam logic [DCS_TIMER_W-1:0] SETUP_LD = DCS_TIMER_W'(LOAD_SETUP_CYC);

  // Index of the lit digit in a one-hot ring state.
  function automatic logic [2:0] ring_idx(input dcs_ring_t r);
    logic [2:0] idx;
    idx = 3'h0;
    for (int k = 0; k < DCS_DIGITS; k++) begin
      if (r[k]) begin
        idx = 3'(k);
      end
    end
    return idx;
  endfunction : ring_idx

  // Next ring state, top digit towards bottom digit and round again.
  function automatic dcs_ring_t ring_adv(input dcs_ring_t r);
    dcs_ring_t n;
    n = RING_D6;
    unique case (r)
      RING_D6: n = RING_D5;
      RING_D5: n = RING_D4;
      RING_D4: n = RING_D3;
      RING_D3: n = RING_D2;
      RING_D2: n = RING_D1;
      RING_D1: n = RING_D6;
      default: n = RING_D6; // A corrupted code recovers at the top.
    endcase
    return n;
  endfunction : ring_adv

  logic count_d1_q; // Count input one clock ago.
  logic scan_d1_q; // Scan input one clock ago.
  logic [1:0] load_d1_q; // Load inputs one clock ago.
  logic [1:0] load_now; // Bit 0 counter load, bit 1 register load.
  logic count_rise;
  logic count_fall;
  logic scan_rise;
  logic [1:0] load_fall;
  logic [DCS_CTRL_W-1:0] ctrl_q; // Software hold and store.
  logic hold; // Counting frozen.
  logic store; // Display latch frozen.
  logic step; // Counter steps this cycle.
  logic clear_async; // Asynchronous clear of the counter only.
  logic [DCS_DIGITS-1:0][3:0] cnt_q; // Counter decades.
  logic [DCS_DIGITS-1:0][3:0] cnt_nx; // Counter after a step.
  logic [DCS_DIGITS:0] chain; // Carry chain through the decades.
  logic [DCS_DIGITS-1:0][3:0] cmp_q; // Compare register.
  logic [DCS_DIGITS-1:0][3:0] latch_q; // Display latch.
  logic [DCS_TIMER_W-1:0] timer_q; // Self-running blank time left.
  logic blank_now; // Interdigit blanking in progress.
  logic blank_q; // Blanking one clock ago.
  logic blank_start;
  logic blank_end;
  logic margin_ok; // Enough blank time left before the strobe rise.
  dcs_ring_t ring_q; // Scan ring.
  dcs_ring_t ring_nx; // Ring after the coming advance.
  logic [2:0] cur_idx; // Digit now strobed.
  logic lz_q; // All digits so far in this scan were zero.
  logic lz_blank_q; // Present digit is a leading zero.
  logic lz_next;
  logic [6:0] seg_pat; // Decoded pattern of the present BCD.
  logic [1:0][DCS_TIMER_W-1:0] age_q; // Cycles each load has been high.
  logic [1:0] pend_q; // Load latched for the strobed digit.
  logic [1:0] inh_q; // Flag inhibit per load kind.
  logic [1:0] rel_q; // Inhibit to end at next blanking start.
  logic zero_inh;
  logic eq_inh;
  logic setup_phase; // APB setup cycle.
  logic hit; // Address maps to a register.
  logic [31:0] rd_mux;

  // Inputs are synchronous pins; one stage of history gives the edges.
  assign load_now = {pins.load_reg, pins.load_cnt};
  assign count_rise = pins.count_in & ~count_d1_q; // RULE25
  assign count_fall = ~pins.count_in & count_d1_q;
  assign scan_rise = pins.scan_in & ~scan_d1_q;
  assign load_fall = ~load_now & load_d1_q;
  assign hold = pins.count_hold | ctrl_q[DCS_CTRL_HOLD];
  assign store = pins.store | ctrl_q[DCS_CTRL_STORE];
  assign step = count_rise & ~hold; // RULE2
  assign clear_async = pins.clear;

  // Edge history registers.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_d1_q <= 1'b0;
      scan_d1_q <= 1'b0;
      load_d1_q <= 2'h0;
    end else begin
      count_d1_q <= pins.count_in;
      scan_d1_q <= pins.scan_in;
      load_d1_q <= load_now;
    end
  end

  // One decade per digit; the ripple of enables makes the count synchronous.
  assign chain[0] = step;
  for (genvar g = 0; g < DCS_DIGITS; g++) begin : g_decade
    dcs_decade u_decade (
      .digit(cnt_q[g]),
      .up(pins.dir_up),
      .en(chain[g]),
      .next(cnt_nx[g]),
      .carry(chain[g+1])
    );
  end

  // Blanking: scan low time plus the self-running time after the rise.
  // The scan-low term is what lets an external drive set the brightness.
  assign blank_now = ~pins.scan_in | ~scan_d1_q | (timer_q != '0); // RULE20 RULE21
  assign blank_start = blank_now & ~blank_q;
  assign blank_end = ~blank_now & blank_q;
  assign margin_ok = ~pins.scan_in | ~scan_d1_q | (timer_q >= SETUP_LD);

  // Blanking timer, reloaded at every scan rise.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_q <= '0;
      blank_q <= 1'b1;
    end else begin
      blank_q <= blank_now;
      if (scan_rise) begin
        timer_q <= BLANK_LD;
      end else if (timer_q != '0) begin
        timer_q <= timer_q - 1'b1;
      end
    end
  end

  // Scan ring; home forces the top digit, the next blanking moves on.
  assign cur_idx = ring_idx(ring_q);
  assign ring_nx = ring_adv(ring_q);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ring_q <= RING_D6;
    end else if (!pins.scan_home_n) begin
      ring_q <= RING_D6; // RULE15 RULE16
    end else if (blank_start) begin
      ring_q <= ring_nx; // RULE14
    end
  end

  // Counter: clear acts at once, loads write the strobed digit.
  always_ff @(posedge pclk or negedge presetn or posedge clear_async) begin
    if (!presetn) begin
      cnt_q <= '0;
    end else if (clear_async) begin
      cnt_q <= '0; // RULE3
    end else begin
      cnt_q <= cnt_nx; // RULE1
      if (blank_start && pend_q[0]) begin
        cnt_q[cur_idx] <= cnt_bcd_in;
      end
    end
  end

  // Compare register: same digit loading, untouched by the clear.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmp_q <= '0;
    end else if (blank_start && pend_q[1]) begin
      cmp_q[cur_idx] <= reg_bcd_in; // RULE11 RULE12
    end
  end

  // Display latch follows the counter unless store freezes it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      latch_q <= '0;
    end else if (!store) begin
      latch_q <= cnt_q; // RULE4
    end
  end

  // Per load kind: setup age, per-digit latch of the request, inhibit.
  // A load seen late in blanking keeps flags inhibited one more digit.
  for (genvar l = 0; l < 2; l++) begin : g_load
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        age_q[l] <= '0;
        pend_q[l] <= 1'b0;
        inh_q[l] <= 1'b0;
        rel_q[l] <= 1'b0;
      end else begin
        if (!load_now[l]) begin
          age_q[l] <= '0;
        end else if (age_q[l] < SETUP_LD) begin
          age_q[l] <= age_q[l] + 1'b1;
        end
        // The request must lead the strobe rise by the setup time.
        if (blank_end) begin
          pend_q[l] <= load_now[l] && (age_q[l] >= SETUP_LD); // RULE23
        end else if (blank_start) begin
          pend_q[l] <= 1'b0;
        end
        // Setting wins over every way of releasing the inhibit.
        if (load_now[l]) begin
          inh_q[l] <= 1'b1; // RULE9
          rel_q[l] <= 1'b0;
        end else if (load_fall[l] && blank_now && margin_ok) begin
          inh_q[l] <= 1'b0; // RULE23
          rel_q[l] <= 1'b0;
        end else if (load_fall[l]) begin
          rel_q[l] <= 1'b1;
        end else if (rel_q[l] && blank_start) begin
          inh_q[l] <= 1'b0; // RULE9
          rel_q[l] <= 1'b0;
        end
      end
    end
  end

  assign zero_inh = inh_q[0] | load_now[0]; // RULE7
  assign eq_inh = inh_q[0] | inh_q[1] | (|load_now); // RULE9

  // Flags judge the value the counter takes at the count edge.
  // Above about 1 MHz the flag periods get too short to be of use.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags <= '0;
    end else begin
      if (count_rise) begin
        flags.zero <= (cnt_nx == '0) & ~zero_inh; // RULE6 RULE24
        flags.equal <= (cnt_nx == cmp_q) & ~eq_inh; // RULE8
        flags.carry <= chain[DCS_DIGITS]; // RULE10
      end else begin
        if (zero_inh) begin
          flags.zero <= 1'b0; // RULE7
        end
        if (eq_inh) begin
          flags.equal <= 1'b0; // RULE9
        end
        if (count_fall) begin
          flags.carry <= 1'b0; // RULE10
        end
      end
    end
  end

  // Leading-zero tracking for the digit that the next blanking brings.
  always_comb begin
    lz_next = (ring_nx == RING_D6) ? 1'b1 : lz_q;
    lz_next = lz_next & (latch_q[ring_idx(ring_nx)] == DCS_BCD_ZERO);
  end

  // BCD output and leading-zero state change at blanking start, and every cycle while scan home is low.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      disp.bcd <= DCS_BCD_ZERO;
      lz_q <= 1'b1;
      lz_blank_q <= 1'b0;
    end else if (!pins.scan_home_n) begin
      disp.bcd <= latch_q[DCS_DIGITS-1]; // RULE16 RULE13
      lz_q <= latch_q[DCS_DIGITS-1] == DCS_BCD_ZERO;
      lz_blank_q <= latch_q[DCS_DIGITS-1] == DCS_BCD_ZERO;
    end else if (blank_start) begin
      disp.bcd <= latch_q[ring_idx(ring_nx)]; // RULE19 RULE13
      lz_q <= lz_next;
      // The bottom digit always shows, so a zero count reads 0.
      lz_blank_q <= lz_next & (ring_nx != RING_D1);
    end
  end

  dcs_seg7 u_seg7 (
    .bcd(disp.bcd),
    .seg(seg_pat)
  );

  // Strobes and segments; both go dark through every blanking interval.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      disp.strobe <= '0;
      disp.seg <= '0;
    end else begin
      disp.strobe <= blank_now ? 6'h00 : ring_q; // RULE17 RULE5
      if (blank_now || !pins.scan_home_n) begin
        disp.seg <= 7'h00; // RULE17 RULE15
      end else if (lz_blank_q && !pins.zero_suppress_disable) begin
        disp.seg <= 7'h00; // RULE18
      end else begin
        disp.seg <= seg_pat; // RULE5
      end
    end
  end

  // APB decode; every access answers in its first access cycle.
  assign setup_phase = psel & ~penable;
  always_comb begin
    hit = 1'b1;
    rd_mux = '0;
    unique case (paddr)
      DCS_REG_CTRL: rd_mux = 32'(ctrl_q);
      DCS_REG_STATUS: begin
        rd_mux[DCS_ST_ZERO] = flags.zero;
        rd_mux[DCS_ST_EQUAL] = flags.equal;
        rd_mux[DCS_ST_CARRY] = flags.carry;
        rd_mux[DCS_ST_INH +: 2] = inh_q;
        rd_mux[DCS_ST_BLANK] = blank_q;
        rd_mux[DCS_ST_RING +: DCS_DIGITS] = ring_q;
      end
      DCS_REG_COUNT: rd_mux = 32'(cnt_q);
      DCS_REG_LATCH: rd_mux = 32'(latch_q);
      DCS_REG_COMPARE: rd_mux = 32'(cmp_q);
      default: hit = 1'b0; // Unmapped reads zero with an error.
    endcase
  end

  // APB answer registers, loaded in the setup cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end else begin
      pready <= setup_phase;
      pslverr <= setup_phase & ~hit;
      if (setup_phase) begin
        prdata <= pwrite ? 32'h0000_0000 : rd_mux;
      end
    end
  end

  // Control register write; read-only registers ignore writes quietly.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= DCS_CTRL_RST;
    end else if (psel && penable && pready && pwrite
                 && paddr == DCS_REG_CTRL) begin
      ctrl_q <= pwdata[DCS_CTRL_W-1:0];
    end
  end

endmodule : dcs_top
`default_nettype wire

// ===== testbench/dcs_top_sva.sv
// Concurrent checks on the ports of the decade counter top.
`timescale 1ns/100ps
`default_nettype none
module dcs_top_sva #(
  parameter int unsigned BLANK_CYC = 8,
  parameter int unsigned LOAD_SETUP_CYC = 3
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [dcs_pkg::DCS_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire dcs_pkg::dcs_pins_t pins,
  input wire logic [3:0] cnt_bcd_in,
  input wire logic [3:0] reg_bcd_in,
  input wire dcs_pkg::dcs_flags_t flags,
  input wire dcs_pkg::dcs_disp_t disp
);
  import dcs_pkg::*;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Cycles since the scan rise, saturating so it never wraps.
  logic [11:0] age_q;
  // Last strobe shown; home_q marks a forced home.
  logic [5:0] last_q;
  logic home_q;
  // Scan age counter.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) age_q <= 12'h000;
    else if (!pins.scan_in) age_q <= 12'h000;
    else if (age_q != 12'hFFF) age_q <= age_q + 12'h001;
  end
  // Strobe history; a home breaks the ring order.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_q <= 6'h00;
      home_q <= 1'b0;
    end else if (!pins.scan_home_n) begin
      home_q <= 1'b1;
    end else if (disp.strobe != 6'h00) begin
      last_q <= disp.strobe;
      home_q <= 1'b0;
    end
  end
  ring_order_a: assert property ($rose(|disp.strobe) && !home_q &&
    last_q != 6'h00 |-> disp.strobe == {last_q[0], last_q[5:1]})
    else $error("strobe order wrong");
  home_blank_a: assert property (!pins.scan_home_n [*3] |->
    disp.seg == 7'h00 && (disp.strobe == 6'h00 || disp.strobe == 6'h20))
    else $error("home not blanked at top digit");
  scan_low_a: assert property (!pins.scan_in [*2] |->
    disp.strobe == 6'h00 && disp.seg == 7'h00)
    else $error("display lit during scan low");
  blank_tail_a: assert property (age_q != 12'h000 && age_q <= BLANK_CYC
    |-> disp.strobe == 6'h00 && disp.seg == 7'h00)
    else $error("display lit inside blanking time");
  flag_edge_a: assert property ($rose(flags.zero) || $rose(flags.equal) ||
    $rose(flags.carry) |-> $past(pins.count_in) && !$past(pins.count_in, 2))
    else $error("flag rose away from count edge");
  carry_drop_a: assert property ($fell(pins.count_in) |=> !flags.carry)
    else $error("carry outlived count pulse");
  zero_inhibit_a: assert property (pins.load_cnt [*3] |-> !flags.zero)
    else $error("zero during counter load");
  equal_inhibit_a: assert property ((pins.load_cnt || pins.load_reg) [*3]
    |-> !flags.equal)
    else $error("equal during load");
  apb_answer_a: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("bus answer not one cycle after setup");
  cover property ($rose(flags.equal));
  cover property ($rose(flags.carry));
  cover property (pready && pslverr);
endmodule : dcs_top_sva
bind dcs_top dcs_top_sva #(.BLANK_CYC(BLANK_CYC),
  .LOAD_SETUP_CYC(LOAD_SETUP_CYC)) u_sva (.*);
`default_nettype wire

// ===== testbench/dcs_switch_model.sv
// Thumbwheel switch bank read back through the digit strobes.
`timescale 1ns/100ps
`default_nettype none
module dcs_switch_model (
  input wire logic [5:0] strobe,
  input wire logic [23:0] cnt_val,
  input wire logic [23:0] reg_val,
  output logic [3:0] cnt_bcd,
  output logic [3:0] reg_bcd
);
  // Diodes OR the strobed decade onto the lines, active high; with no
  // strobe the pull-downs win.
  always_comb begin
    cnt_bcd = 4'h0;
    reg_bcd = 4'h0;
    for (int i = 0; i < 6; i++) begin
      if (strobe[i]) begin
        cnt_bcd = cnt_bcd | cnt_val[i*4 +: 4];
        reg_bcd = reg_bcd | reg_val[i*4 +: 4];
      end
    end
  end
endmodule : dcs_switch_model
`default_nettype wire

// ===== testbench/tb_decade_counter_compare_scan.sv
// Self-checking bench for the decade counter, compare and scan block.
`timescale 1ns/100ps
`default_nettype none
module tb_decade_counter_compare_scan;
  import dcs_pkg::*;
  // Short timings keep each scan step to a few cycles.
  localparam int unsigned BLANK = 8;
  localparam int unsigned SETUP = 3;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [DCS_AW-1:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  dcs_pins_t pins = '{dir_up: 1'b1, scan_home_n: 1'b1, default: 1'b0};
  logic [3:0] cnt_bcd;
  logic [3:0] reg_bcd;
  dcs_flags_t flags;
  dcs_disp_t disp;
  logic [23:0] cnt_val = 24'h000000;
  logic [23:0] reg_val = 24'h000000;
  logic [7:0] scan_ph = 8'h00;
  logic [31:0] rd;
  logic err;
  dcs_flags_t fl;
  int failures = 0;
  int samples_checked = 0;

  dcs_top #(.BLANK_CYC(BLANK), .LOAD_SETUP_CYC(SETUP)) dut (.*,
    .cnt_bcd_in(cnt_bcd), .reg_bcd_in(reg_bcd));
  dcs_switch_model u_sw (.strobe(disp.strobe), .cnt_val, .reg_val,
    .cnt_bcd, .reg_bcd);

  // Free-running clock.
  always #5 pclk = ~pclk;

  // External scan: three low cycles in every twenty-four.
  always @(posedge pclk) begin
    scan_ph <= (scan_ph == 8'h17) ? 8'h00 : scan_ph + 8'h01;
    pins.scan_in <= (scan_ph >= 8'h03);
  end

  // Counts a comparison; reports a mismatch at once.
  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // One bus transfer; the answer is taken where pready is high.
  task automatic apb(input logic wr, input logic [DCS_AW-1:0] a,
                     input logic [31:0] d);
    int n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 50) begin
      @(posedge pclk);
      n++;
    end
    if (n == 50) failures++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Reads a register and compares it.
  task automatic rdchk(input string what, input logic [DCS_AW-1:0] a,
                       input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(what, exp, rd);
  endtask : rdchk

  // One count pulse; flags are taken while it is high.
  task automatic pulse();
    @(posedge pclk);
    pins.count_in <= 1'b1;
    repeat (3) @(posedge pclk);
    fl = flags;
    pins.count_in <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask : pulse

  // Waits, bounded, for a strobe pattern and checks it.
  task automatic wait_strobe(input logic [5:0] v);
    int n = 0;
    while (disp.strobe !== v && n < 500) begin
      @(posedge pclk);
      n++;
    end
    chk("strobe", {26'h0, v}, {26'h0, disp.strobe});
  endtask : wait_strobe

  // Register access kinds and the unmapped hole.
  task automatic t_regs();
    rdchk("ctrl reset", DCS_REG_CTRL, 32'h0);
    apb(1'b1, DCS_REG_CTRL, 32'h3);
    rdchk("ctrl rw", DCS_REG_CTRL, 32'h3);
    apb(1'b1, DCS_REG_CTRL, 32'h0);
    apb(1'b1, DCS_REG_COUNT, 32'h00123456);
    rdchk("count ro", DCS_REG_COUNT, 32'h0);
    apb(1'b0, 12'h014, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, err});
    chk("unmapped data", 32'h0, rd);
  endtask : t_regs

  // Wraps both ways, zero flag, and both kinds of hold.
  task automatic t_count();
    pins.dir_up <= 1'b0;
    pulse();
    rdchk("down wrap", DCS_REG_COUNT, 32'h00999999);
    chk("borrow", 32'h1, {31'h0, fl.carry});
    pins.dir_up <= 1'b1;
    pulse();
    rdchk("up wrap", DCS_REG_COUNT, 32'h0);
    chk("carry", 32'h1, {31'h0, fl.carry});
    chk("zero", 32'h1, {31'h0, fl.zero});
    pulse();
    chk("zero once", 32'h0, {31'h0, fl.zero});
    pins.count_hold <= 1'b1;
    pulse();
    rdchk("hold pin", DCS_REG_COUNT, 32'h1);
    pins.count_hold <= 1'b0;
    apb(1'b1, DCS_REG_CTRL, 32'h1);
    pulse();
    rdchk("hold soft", DCS_REG_COUNT, 32'h1);
    apb(1'b1, DCS_REG_CTRL, 32'h0);
    pulse();
    pulse();
    rdchk("count three", DCS_REG_COUNT, 32'h3);
  endtask : t_count

  // Forced home, ring restart and leading-zero blanking on 000003.
  task automatic t_display();
    pins.scan_home_n <= 1'b0;
    repeat (60) @(posedge pclk);
    chk("home seg", 32'h0, {25'h0, disp.seg});
    chk("home bcd", 32'h0, {28'h0, disp.bcd});
    wait_strobe(6'h20);
    pins.scan_home_n <= 1'b1;
    wait_strobe(6'h00);
    wait_strobe(6'h10);
    wait_strobe(6'h20);
    chk("lz blank", 32'h0, {25'h0, disp.seg});
    wait_strobe(6'h01);
    chk("d1 seg", 32'h4F, {25'h0, disp.seg});
    chk("d1 bcd", 32'h3, {28'h0, disp.bcd});
    pins.zero_suppress_disable <= 1'b1;
    wait_strobe(6'h00);
    wait_strobe(6'h20);
    chk("lz off", 32'h3F, {25'h0, disp.seg});
    pins.zero_suppress_disable <= 1'b0;
  endtask : t_display

  // Loads both banks, then counts onto the compare value.
  task automatic t_load();
    cnt_val <= 24'h123455;
    reg_val <= 24'h123456;
    pins.load_cnt <= 1'b1;
    pins.load_reg <= 1'b1;
    repeat (200) @(posedge pclk);
    // Release at a scan rise so the switch data cannot be half sampled.
    while (scan_ph != 8'd3) @(posedge pclk);
    pins.load_cnt <= 1'b0;
    pins.load_reg <= 1'b0;
    repeat (60) @(posedge pclk);
    rdchk("cnt load", DCS_REG_COUNT, 32'h00123455);
    rdchk("reg load", DCS_REG_COMPARE, 32'h00123456);
    pulse();
    chk("equal", 32'h1, {31'h0, fl.equal});
    pulse();
    chk("equal once", 32'h0, {31'h0, fl.equal});
    wait_strobe(6'h00);
    wait_strobe(6'h01);
    chk("bcd shows count", 32'h7, {28'h0, disp.bcd});
  endtask : t_load

  // Store freezes the latch; clear hits only the counter.
  task automatic t_clear();
    pins.store <= 1'b1;
    pulse();
    rdchk("latch held", DCS_REG_LATCH, 32'h00123457);
    rdchk("count on", DCS_REG_COUNT, 32'h00123458);
    pins.clear <= 1'b1;
    repeat (3) @(posedge pclk);
    pins.clear <= 1'b0;
    rdchk("clear count", DCS_REG_COUNT, 32'h0);
    rdchk("clear latch", DCS_REG_LATCH, 32'h00123457);
    rdchk("clear reg", DCS_REG_COMPARE, 32'h00123456);
    pins.store <= 1'b0;
    repeat (2) @(posedge pclk);
    rdchk("latch follows", DCS_REG_LATCH, 32'h0);
  endtask : t_clear

  // Prints counts and verdict, then ends the run.
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : wrap_up

  // Main sequence after five reset cycles.
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_count();
    t_display();
    t_load();
    t_clear();
    wrap_up();
  end

  // The run needs some one thousand cycles; wide margin.
  initial begin
    repeat (20000) @(posedge pclk);
    failures++;
    wrap_up();
  end
endmodule : tb_decade_counter_compare_scan
`default_nettype wire
